/* hdl/rsc_pkg.sv */
// Package with register map, field positions and reset values of the receive control block.
package rsc_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] RSC_OFS_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] RSC_OFS_RX_DATA        = 4'h1;
	localparam logic [3:0] RSC_OFS_MODE           = 4'h2;
	localparam logic [3:0] RSC_OFS_IRQ_STATUS     = 4'h3;
	localparam logic [3:0] RSC_OFS_IRQ_MASK       = 4'h4;

	// ----------------------------------------
	// Field positions of receive_status_control
	// ----------------------------------------
	localparam int RSC_BIT_PORT_ENABLE  = 7;
	localparam int RSC_BIT_NINE_BIT     = 6;
	localparam int RSC_BIT_ONE_SHOT     = 5;
	localparam int RSC_BIT_CONTINUOUS   = 4;
	localparam int RSC_BIT_ADDR_DETECT  = 3;
	localparam int RSC_BIT_FRAMING_ERR  = 2;
	localparam int RSC_BIT_OVERRUN_ERR  = 1;
	localparam int RSC_BIT_NINTH_BIT    = 0;

	// ----------------------------------------
	// Field positions of mode and interrupt registers
	// ----------------------------------------
	localparam int RSC_BIT_SYNC_MODE    = 0;
	localparam int RSC_BIT_SYNC_MASTER  = 1;
	localparam int RSC_IRQ_RX_CHAR      = 0;
	localparam int RSC_IRQ_OVERRUN      = 1;
	localparam int RSC_IRQ_FRAMING      = 2;
	localparam int RSC_IRQ_WIDTH        = 3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RSC_RST_STATUS_CONTROL = 8'h00;
	localparam logic [1:0] RSC_RST_MODE           = 2'h0;
	localparam logic [2:0] RSC_RST_IRQ_MASK       = 3'h0;

endpackage

/* hdl/rsc_rx_hold.sv */
// Receive buffer holding the character at the head of the receive path.
`timescale 1ns/10ps
module rsc_rx_hold
(
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       load_i,
	input  wire logic       pop_i,
	input  wire logic       clear_i,
	// Character in
	input  wire logic [8:0] char_i,
	input  wire logic       framing_error_flag_i,
	// Buffer view
	output logic            full_o,
	output logic [7:0]      data_o,
	output logic            ninth_o,
	output logic            framing_error_flag_o
);
	import rsc_pkg::*;

	typedef struct packed {
		logic       full;
		logic [8:0] char_val;
		logic       framing_error_flag;
	} rsc_hold_t;

	rsc_hold_t st;
	rsc_hold_t next_st;

	// ----------------------------------------
	// Load and pop
	// ----------------------------------------
	// The value stays after a pop, so flags keep describing it until the next load or clear.
	always_comb
	begin
		next_st = st;
		if (pop_i)
		begin
			next_st.full = 1'b0;
		end
		if (load_i)
		begin
			next_st.full     = 1'b1;
			next_st.char_val = char_i;
			next_st.framing_error_flag     = framing_error_flag_i;
		end
		if (clear_i)
		begin
			next_st = '0;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign full_o  = st.full;
	assign data_o  = st.char_val[7:0];
	assign ninth_o = st.char_val[8];
	assign framing_error_flag_o  = st.framing_error_flag;

endmodule

/* hdl/rsc_receive_control.sv */
// Receive control and status logic of a serial port with register access and interrupt.
`timescale 1ns/10ps
module rsc_receive_control
(
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// Register port
	input  wire logic [3:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// Character from the bit sampler
	input  wire logic       char_valid_i,
	input  wire logic [8:0] char_data_i,
	input  wire logic       char_framing_error_flag_i,
	// Line side control
	output logic            port_pins_o,
	output logic            rx_listen_o,
	output logic            sync_clock_req_o,
	// Interrupt
	output logic            irq_o
);
	import rsc_pkg::*;

	typedef struct packed {
		logic                     serial_port_enable;
		logic                     nine;
		logic                     one_shot_rx_enable;
		logic                     continuous_rx_enable;
		logic                     address_detect_enable;
		logic                     overrun_error_flag;
		logic                     sync_mode;
		logic                     master;
		logic [RSC_IRQ_WIDTH-1:0] irq_stat;
		logic [RSC_IRQ_WIDTH-1:0] irq_mask;
		logic [7:0]               rdata;
	} rsc_state_t;

	rsc_state_t st;
	rsc_state_t next_st;

	logic       rx_enabled;
	logic       addr_pass;
	logic       accept;
	logic       load;
	logic       pop;
	logic       lost;
	logic       port_clear;
	logic       ctrl_wr;
	logic [8:0] char_in;
	logic       hold_full;
	logic [7:0] hold_data;
	logic       hold_ninth;
	logic       hold_framing_error_flag;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
		hit = (addr == ofs);
	endfunction

	assign ctrl_wr = reg_wr_i && hit(reg_addr_i, RSC_OFS_STATUS_CONTROL);
	assign pop     = reg_rd_i && hit(reg_addr_i, RSC_OFS_RX_DATA);

	// ----------------------------------------
	// Receive enable and character acceptance
	// ----------------------------------------
	// Async uses only the continuous field; sync master may also use one-shot.
	always_comb
	begin
		if (st.sync_mode)
		begin
			rx_enabled = st.continuous_rx_enable || (st.master && st.one_shot_rx_enable);
		end
		else
		begin
			rx_enabled = st.continuous_rx_enable;
		end
	end

	// Address filtering applies to async nine-bit reception only.
	assign addr_pass  = !(!st.sync_mode && st.nine && st.address_detect_enable) || char_data_i[8];
	assign accept     = st.serial_port_enable && rx_enabled && char_valid_i && !st.overrun_error_flag && addr_pass;
	assign lost       = accept && hold_full && !pop;
	assign load       = accept && !lost;
	assign port_clear = !st.serial_port_enable;
	assign char_in    = {st.nine && char_data_i[8], char_data_i[7:0]};

	rsc_rx_hold u_hold
	(
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.load_i    (load),
		.pop_i     (pop),
		.clear_i   (port_clear),
		.char_i    (char_in),
		.framing_error_flag_i    (char_framing_error_flag_i),
		.full_o    (hold_full),
		.data_o    (hold_data),
		.ninth_o   (hold_ninth),
		.framing_error_flag_o    (hold_framing_error_flag)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_st = st;
		// Hardware ends a one-shot reception once its character completes.
		if (st.serial_port_enable && st.sync_mode && st.master && st.one_shot_rx_enable && !st.continuous_rx_enable && char_valid_i)
		begin
			next_st.one_shot_rx_enable = 1'b0;
		end
		if (ctrl_wr)
		begin
			next_st.serial_port_enable  = reg_wdata_i[RSC_BIT_PORT_ENABLE];
			next_st.nine  = reg_wdata_i[RSC_BIT_NINE_BIT];
			next_st.one_shot_rx_enable  = reg_wdata_i[RSC_BIT_ONE_SHOT];
			next_st.continuous_rx_enable  = reg_wdata_i[RSC_BIT_CONTINUOUS];
			next_st.address_detect_enable = reg_wdata_i[RSC_BIT_ADDR_DETECT];
			if (!reg_wdata_i[RSC_BIT_CONTINUOUS])
			begin
				next_st.overrun_error_flag = 1'b0;
			end
		end
		if (reg_wr_i && hit(reg_addr_i, RSC_OFS_MODE))
		begin
			next_st.sync_mode = reg_wdata_i[RSC_BIT_SYNC_MODE];
			next_st.master    = reg_wdata_i[RSC_BIT_SYNC_MASTER];
		end
		if (reg_wr_i && hit(reg_addr_i, RSC_OFS_IRQ_MASK))
		begin
			next_st.irq_mask = reg_wdata_i[RSC_IRQ_WIDTH-1:0];
		end
		if (port_clear)
		begin
			next_st.overrun_error_flag = 1'b0;
		end
		// Read data, with read side effects.
		next_st.rdata = 8'h00;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				RSC_OFS_STATUS_CONTROL:
				begin
					next_st.rdata = {st.serial_port_enable, st.nine, st.one_shot_rx_enable, st.continuous_rx_enable, st.address_detect_enable,
						hold_framing_error_flag, st.overrun_error_flag, hold_ninth};
				end
				RSC_OFS_RX_DATA:
				begin
					next_st.rdata = hold_data;
				end
				RSC_OFS_MODE:
				begin
					next_st.rdata = {6'h00, st.master, st.sync_mode};
				end
				RSC_OFS_IRQ_STATUS:
				begin
					next_st.rdata = {5'h00, st.irq_stat};
					next_st.irq_stat = '0;
				end
				RSC_OFS_IRQ_MASK:
				begin
					next_st.rdata = {5'h00, st.irq_mask};
				end
				default:
				begin
					next_st.rdata = 8'h00;
				end
			endcase
		end
		// Events set after any clear, so a set in the clearing cycle survives.
		if (lost)
		begin
			next_st.overrun_error_flag = 1'b1;
			next_st.irq_stat[RSC_IRQ_OVERRUN] = 1'b1;
		end
		if (load)
		begin
			next_st.irq_stat[RSC_IRQ_RX_CHAR] = 1'b1;
			if (char_framing_error_flag_i)
			begin
				next_st.irq_stat[RSC_IRQ_FRAMING] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			st           <= '0;
			st.serial_port_enable      <= RSC_RST_STATUS_CONTROL[RSC_BIT_PORT_ENABLE];
			st.nine      <= RSC_RST_STATUS_CONTROL[RSC_BIT_NINE_BIT];
			st.one_shot_rx_enable      <= RSC_RST_STATUS_CONTROL[RSC_BIT_ONE_SHOT];
			st.continuous_rx_enable      <= RSC_RST_STATUS_CONTROL[RSC_BIT_CONTINUOUS];
			st.address_detect_enable     <= RSC_RST_STATUS_CONTROL[RSC_BIT_ADDR_DETECT];
			st.sync_mode <= RSC_RST_MODE[RSC_BIT_SYNC_MODE];
			st.master    <= RSC_RST_MODE[RSC_BIT_SYNC_MASTER];
			st.irq_mask  <= RSC_RST_IRQ_MASK;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_o      = st.rdata;
	assign port_pins_o      = st.serial_port_enable;
	assign rx_listen_o      = st.serial_port_enable && rx_enabled && !st.overrun_error_flag;
	assign sync_clock_req_o = st.serial_port_enable && st.sync_mode && st.master && rx_enabled;
	assign irq_o            = |(st.irq_stat & st.irq_mask);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// Helper signals watched by the assertions.
	logic irq_stat_seen;
	logic serial_port_enable_set;

	assign irq_stat_seen = st.irq_stat[RSC_IRQ_RX_CHAR];
	assign serial_port_enable_set      = ctrl_wr && reg_wdata_i[RSC_BIT_PORT_ENABLE];

	sequence seq_char_load;
		load;
	endsequence

	sequence seq_one_shot_done;
		st.serial_port_enable && st.sync_mode && st.master && st.one_shot_rx_enable && !st.continuous_rx_enable && char_valid_i && !ctrl_wr;
	endsequence

	sequence seq_cont_cleared;
		ctrl_wr && !reg_wdata_i[RSC_BIT_CONTINUOUS];
	endsequence

	sequence seq_addr_miss;
		char_valid_i && !st.sync_mode && st.nine && st.address_detect_enable && !char_data_i[8];
	endsequence

	chk_nine_bit_strip: assert property (seq_char_load and !st.nine |=> !hold_ninth)
		else $error("Eight-bit reception kept a ninth bit.");

	chk_ninth_bit_view: assert property (seq_char_load and st.nine
		|=> hold_ninth == $past(char_data_i[8]) && hold_full)
		else $error("Buffered ninth bit does not match the received one.");

	chk_one_shot_clear: assert property (seq_one_shot_done |=> !st.one_shot_rx_enable ##1 !st.one_shot_rx_enable[*2])
		else $error("One-shot receive not cleared after the character.");

	chk_async_disable: assert property (!st.sync_mode && !st.continuous_rx_enable |-> !load && !rx_listen_o)
		else $error("Async receiver active with continuous field clear.");

	chk_cont_overrides: assert property (st.serial_port_enable && st.sync_mode && st.continuous_rx_enable && st.one_shot_rx_enable
		&& !ctrl_wr |=> st.continuous_rx_enable && st.one_shot_rx_enable)
		else $error("Continuous reception did not override one-shot.");

	chk_addr_filter: assert property (seq_char_load and !st.sync_mode && st.nine
		&& st.address_detect_enable |-> char_data_i[8] ##1 irq_stat_seen)
		else $error("Address detect accepted a character without ninth bit.");

	chk_all_accept: assert property (st.serial_port_enable && st.continuous_rx_enable && !st.sync_mode && !(st.nine
		&& st.address_detect_enable) && char_valid_i && !st.overrun_error_flag && !hold_full |-> load)
		else $error("Character dropped with address detection off.");

	chk_framing_error_flag_follow: assert property (seq_char_load |=> hold_framing_error_flag == $past(char_framing_error_flag_i))
		else $error("Framing flag does not follow the buffered character.");

	chk_overrun_set: assert property (lost |=> st.overrun_error_flag && !load)
		else $error("Lost character did not set the overrun flag.");

	chk_overrun_hold: assert property (st.overrun_error_flag && st.serial_port_enable && !(ctrl_wr
		&& !reg_wdata_i[RSC_BIT_CONTINUOUS]) |=> st.overrun_error_flag)
		else $error("Overrun flag cleared without clearing continuous receive.");

	chk_port_reset: assert property (!st.serial_port_enable |=> !hold_full && !st.overrun_error_flag
		&& port_pins_o == $past(serial_port_enable_set))
		else $error("Disabled port not held in reset.");

	chk_one_shot_ignored: assert property ((!st.sync_mode || !st.master) && !st.continuous_rx_enable
		|-> !load && !sync_clock_req_o)
		else $error("One-shot receive acted outside synchronous master mode.");

	chk_disabled_idle: assert property (!st.serial_port_enable |-> !load && !rx_listen_o)
		else $error("Disabled port accepted a character.");

	chk_async_listen: assert property (st.serial_port_enable && !st.sync_mode && st.continuous_rx_enable && !st.overrun_error_flag
		|-> rx_listen_o)
		else $error("Async receiver idle with continuous field set.");

	chk_sync_listen: assert property (st.serial_port_enable && st.sync_mode && st.continuous_rx_enable && !st.overrun_error_flag
		|-> rx_listen_o)
		else $error("Sync receiver idle with continuous field set.");

	chk_one_shot_listen: assert property (st.serial_port_enable && st.sync_mode && st.master && st.one_shot_rx_enable
		&& !st.overrun_error_flag |-> rx_listen_o && sync_clock_req_o)
		else $error("One-shot receive did not start reception.");

	chk_one_shot_kept: assert property ((!st.sync_mode || !st.master) && st.one_shot_rx_enable
		&& !ctrl_wr |=> st.one_shot_rx_enable)
		else $error("One-shot field cleared outside synchronous master mode.");

	chk_overrun_clear: assert property (seq_cont_cleared and !lost |=> !st.overrun_error_flag)
		else $error("Overrun flag kept after clearing continuous receive.");

	chk_overrun_stop: assert property (st.overrun_error_flag |-> !load && !rx_listen_o)
		else $error("Receiver kept loading after an overrun.");

	chk_overrun_keep: assert property (lost |=> $stable(hold_data) && hold_full)
		else $error("Lost character overwrote the buffered one.");

	chk_addr_reject: assert property (seq_addr_miss |-> !load)
		else $error("Address detect loaded a character without ninth bit.");

	chk_irq_on_load: assert property (seq_char_load |=> irq_stat_seen)
		else $error("Loaded character did not raise the receive status bit.");

	chk_eight_bit_all: assert property (st.serial_port_enable && st.continuous_rx_enable && !st.nine && char_valid_i
		&& !st.overrun_error_flag && !hold_full |-> load)
		else $error("Eight-bit character dropped although address detect is ignored.");

	chk_data_view: assert property (seq_char_load
		|=> hold_data == $past(char_data_i[7:0]) && hold_full)
		else $error("Buffered data does not match the received character.");

	chk_framing_error_flag_steady: assert property (!load && !port_clear |=> $stable(hold_framing_error_flag))
		else $error("Framing flag changed without a new character.");

	chk_ninth_steady: assert property (!load && !port_clear |=> $stable(hold_ninth))
		else $error("Ninth bit changed without a new character.");

endmodule

/* tb/rsc_char_src.sv */
// Model of the bit sampler that hands completed characters to the block.
`timescale 1ns/10ps
module rsc_char_src
(
	// Clock
	input  wire logic       clk_sys_i,
	// Request from the bench
	input  wire logic       go_i,
	input  wire logic [8:0] data_i,
	input  wire logic       framing_error_flag_i,
	// Character out
	output logic            char_valid_o,
	output logic [8:0]      char_data_o,
	output logic            char_framing_error_flag_o
);
	logic [8:0] last = 9'h000;
	always @(posedge clk_sys_i)
		if (go_i)
			last <= data_i;
	// Between characters the lines carry the inverse of the last one.
	assign char_valid_o = go_i;
	assign char_data_o  = go_i ? data_i : ~last;
	assign char_framing_error_flag_o  = go_i ? framing_error_flag_i : ~framing_error_flag_i;
endmodule

/* tb/tb.sv */
// Self-checking bench of the receive control block.
`timescale 1ns/10ps
module tb;
	import rsc_pkg::*;
	logic        clk_sys_i   = 1'h0;
	logic        rst_i       = 1'h1;
	logic [3:0]  reg_addr_i  = 4'h0;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        reg_wr_i    = 1'h0;
	logic        reg_rd_i    = 1'h0;
	logic [7:0]  reg_rdata_o;
	logic        go          = 1'h0;
	logic [8:0]  cdata       = 9'h000;
	logic        cferr       = 1'h0;
	logic        char_valid;
	logic [8:0]  char_data;
	logic        char_framing_error_flag;
	logic        port_pins_o;
	logic        rx_listen_o;
	logic        sync_clock_req_o;
	logic        irq_o;
	logic [7:0]  exp_q[$];
	logic        rd_q        = 1'h0;
	logic [31:0] seed        = 32'h00000030;
	logic [8:0]  d;
	logic        f;
	int          fails       = 0;
	int          n_compared  = 0;
	int          cycles      = 0;

	rsc_char_src i_src (.clk_sys_i(clk_sys_i), .go_i(go), .data_i(cdata), .framing_error_flag_i(cferr),
		.char_valid_o(char_valid), .char_data_o(char_data), .char_framing_error_flag_o(char_framing_error_flag));
	rsc_receive_control i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .char_valid_i(char_valid), .char_data_i(char_data),
		.char_framing_error_flag_i(char_framing_error_flag), .port_pins_o(port_pins_o), .rx_listen_o(rx_listen_o),
		.sync_clock_req_o(sync_clock_req_o), .irq_o(irq_o));

	initial
		forever #4 clk_sys_i = ~clk_sys_i;

	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic ck1(input string n, input logic e, input logic s);
		chk(n, {7'h00, e}, {7'h00, s});
	endtask

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic wr(input logic [3:0] a, input logic [7:0] dv);
		@(posedge clk_sys_i);
		reg_addr_i  <= a;
		reg_wdata_i <= dv;
		reg_wr_i    <= 1'h1;
		@(posedge clk_sys_i);
		reg_wr_i    <= 1'h0;
		#2;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'h1;
		exp_q.push_back(e);
		@(posedge clk_sys_i);
		reg_rd_i   <= 1'h0;
		#2;
	endtask

	task automatic snd(input logic [8:0] dv, input logic fv);
		@(posedge clk_sys_i);
		go    <= 1'h1;
		cdata <= dv;
		cferr <= fv;
		@(posedge clk_sys_i);
		go    <= 1'h0;
		#2;
	endtask

	// ----------------------------------------
	// Read data monitor and timeout
	// ----------------------------------------
	always @(posedge clk_sys_i)
	begin
		if (rd_q)
			chk("reg_rdata_o", exp_q.pop_front(), reg_rdata_o);
		rd_q <= reg_rd_i;
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			stop_test();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'h0;
		rd(4'h0, 8'h00);
		rd(4'h2, 8'h00);
		rd(4'hF, 8'h00);
		ck1("port_pins_o", 1'h0, port_pins_o);
		wr(4'h4, 8'h07);
		wr(4'h0, 8'hD0);
		ck1("port_pins_o", 1'h1, port_pins_o);
		ck1("rx_listen_o", 1'h1, rx_listen_o);
		for (int i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			d = seed[8:0];
			f = seed[9];
			snd(d, f);
			ck1("irq_o", 1'h1, irq_o);
			rd(4'h0, 8'hD0 | {5'h00, f, 1'h0, d[8]});
			rd(4'h1, d[7:0]);
			rd(4'h3, 8'h01 | {5'h00, f, 2'h0});
			ck1("irq_o", 1'h0, irq_o);
		end
		wr(4'h0, 8'hD8);
		snd(9'h012, 1'h0);
		rd(4'h3, 8'h00);
		snd(9'h134, 1'h1);
		rd(4'h0, 8'hDD);
		rd(4'h1, 8'h34);
		rd(4'h3, 8'h05);
		wr(4'h0, 8'h98);
		snd(9'h077, 1'h0);
		rd(4'h0, 8'h98);
		snd(9'h1C3, 1'h0);
		rd(4'h0, 8'h9A);
		ck1("rx_listen_o", 1'h0, rx_listen_o);
		rd(4'h1, 8'h77);
		snd(9'h1C3, 1'h0);
		rd(4'h3, 8'h03);
		wr(4'h0, 8'h98);
		rd(4'h0, 8'h9A);
		wr(4'h0, 8'h88);
		rd(4'h0, 8'h88);
		wr(4'h0, 8'h98);
		snd(9'h1C3, 1'h0);
		rd(4'h0, 8'h98);
		rd(4'h1, 8'hC3);
		rd(4'h3, 8'h01);
		wr(4'h0, 8'hA0);
		ck1("rx_listen_o", 1'h0, rx_listen_o);
		snd(9'h011, 1'h0);
		rd(4'h3, 8'h00);
		rd(4'h0, 8'hA0);
		wr(4'h2, 8'h03);
		ck1("sync_clock_req_o", 1'h1, sync_clock_req_o);
		wr(4'h0, 8'hE0);
		snd(9'h15A, 1'h0);
		rd(4'h0, 8'hC1);
		rd(4'h1, 8'h5A);
		snd(9'h022, 1'h0);
		rd(4'h3, 8'h01);
		wr(4'h0, 8'hF0);
		snd(9'h0A1, 1'h0);
		rd(4'h1, 8'hA1);
		snd(9'h1B2, 1'h0);
		rd(4'h0, 8'hF1);
		rd(4'h1, 8'hB2);
		wr(4'h2, 8'h01);
		wr(4'h0, 8'hE0);
		ck1("rx_listen_o", 1'h0, rx_listen_o);
		ck1("sync_clock_req_o", 1'h0, sync_clock_req_o);
		wr(4'h4, 8'h00);
		wr(4'h2, 8'h00);
		wr(4'h0, 8'hD0);
		snd(9'h011, 1'h0);
		ck1("irq_o", 1'h0, irq_o);
		wr(4'h4, 8'h01);
		ck1("irq_o", 1'h1, irq_o);
		rd(4'h3, 8'h01);
		ck1("irq_o", 1'h0, irq_o);
		wr(4'h0, 8'h50);
		ck1("port_pins_o", 1'h0, port_pins_o);
		wr(4'h0, 8'hD0);
		snd(9'h033, 1'h0);
		rd(4'h0, 8'hD0);
		rd(4'h1, 8'h33);
		repeat (3) @(posedge clk_sys_i);
		stop_test();
	end
endmodule
